// [rot_consts.vh]
// Offsets, field positions, reset values and limits for the rotate datapath
`ifndef ROT_CONSTS_VH
`define ROT_CONSTS_VH

// ****************************************
// Register byte offsets on APB
// ****************************************
`define ROT_OFF_CTRL      12'h000
`define ROT_OFF_INSTR     12'h004
`define ROT_OFF_BANK      12'h008
`define ROT_OFF_WREG      12'h00C
`define ROT_OFF_STATUS    12'h010
`define ROT_OFF_IDXBASE   12'h014
`define ROT_OFF_MEMADDR   12'h018
`define ROT_OFF_MEMDATA   12'h01C
`define ROT_OFF_LASTEA    12'h020

// ****************************************
// Field positions
// ****************************************
`define ROT_CTRL_START    0
`define ROT_CTRL_EXT      1
`define ROT_INSTR_F_LSB   0
`define ROT_INSTR_F_MSB   7
`define ROT_INSTR_D       8
`define ROT_INSTR_A       9
`define ROT_INSTR_OP      10
`define ROT_STAT_CARRY    0
`define ROT_STAT_BUSY     1
`define ROT_STAT_DONE     2

// ****************************************
// Reset values and addressing limits
// ****************************************
`define ROT_INSTR_RST     11'h300
`define ROT_BANK_RST      4'h0
`define ROT_WREG_RST      8'h00
`define ROT_IDX_RST       12'h000
`define ROT_ILO_LIMIT     8'h5F
`define ROT_ACC_SPLIT     8'h60
`define ROT_ACC_HI_BANK   4'hF
`define ROT_OP_RLNC       1'b0
`define ROT_OP_RRC        1'b1

`endif

// [rot_rotator.v]
// Rotate unit: left without carry, right through carry
`timescale 1ns/1ps
`include "rot_consts.vh"

module rot_rotator
(
  op,
  operand,
  carry_in,
  result,
  carry_out
);
  input  wire       op;
  input  wire [7:0] operand;
  input  wire       carry_in;
  output reg  [7:0] result;
  output reg        carry_out;

  always @*
  begin
    if (op == `ROT_OP_RRC)
    begin
      result    = {carry_in, operand[7:1]};
      carry_out = operand[0];
    end
    else
    begin
      result    = {operand[6:0], operand[7]};
      carry_out = carry_in;
    end
  end
endmodule

// [rot_addr_resolve.v]
// Operand address resolution: access bank, bank select, indexed literal offset
`timescale 1ns/1ps
`include "rot_consts.vh"

module rot_addr_resolve
(
  file_addr,
  access_bit,
  ext_en,
  bank_sel,
  index_base,
  eff_addr
);
  input  wire [7:0]  file_addr;
  input  wire        access_bit;
  input  wire        ext_en;
  input  wire [3:0]  bank_sel;
  input  wire [11:0] index_base;
  output reg  [11:0] eff_addr;

  always @*
  begin
    if (access_bit)
      eff_addr = {bank_sel, file_addr};
    else if (ext_en && (file_addr <= `ROT_ILO_LIMIT))
      eff_addr = index_base + {4'h0, file_addr};
    else if (file_addr < `ROT_ACC_SPLIT)
      eff_addr = {4'h0, file_addr};
    else
      eff_addr = {`ROT_ACC_HI_BANK, file_addr};
  end
endmodule

// [rot_datapath.v]
// Rotate instruction datapath with data memory and APB register access
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "rot_consts.vh"

// Overview of operation
// - Left rotate, bit 7 wraps, carry kept
// - Right rotate through carry flag
// - Destination bit 0 to W, 1 to file
// - Access bit 0 selects fixed access bank
// - Access bit 1 uses bank select register
// - Extended set, access bit 0, low addresses use indexed offset
module rot_datapath
#(
  parameter MEM_AW = 12
)
(
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr
);
  input  wire        pclk;
  input  wire        presetn;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [11:0] paddr;
  input  wire [31:0] pwdata;
  output reg  [31:0] prdata;
  output wire        pready;
  output wire        pslverr;

  // ****************************************
  // Quarter phase states
  // ****************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_Q1   = 5'h02;
  localparam [4:0] ST_Q2   = 5'h04;
  localparam [4:0] ST_Q3   = 5'h08;
  localparam [4:0] ST_Q4   = 5'h10;

  reg  [4:0]        state_ff;
  reg  [4:0]        nxt_state;
  reg  [10:0]       instr_ff;
  reg  [10:0]       exec_instr_ff;
  reg               ext_en_ff;
  reg  [3:0]        bank_select_reg_ff;
  reg  [7:0]        wreg_ff;
  reg               carry_ff;
  reg               done_ff;
  reg  [11:0]       index_base_ff;
  reg  [MEM_AW-1:0] mem_addr_ff;
  reg  [11:0]       ea_ff;
  reg  [7:0]        operand_ff;
  reg  [7:0]        result_ff;
  reg               carry_new_ff;
  reg  [7:0]        mem [0:(1<<MEM_AW)-1];
  wire [11:0]       ea_comb;
  wire [7:0]        rot_result;
  wire              rot_carry;
  wire              busy;
  wire              setup_ph;
  wire              acc_ph;
  wire              wr_acc;
  wire              addr_ok;
  wire              ro_reg;
  wire              busy_refuse;
  wire              start_req;
  wire              dest_file;
  wire [MEM_AW-1:0] core_idx;
  reg  [31:0]       rd_mux;

  assign busy     = (state_ff != ST_IDLE);
  assign setup_ph = psel & ~penable;
  assign acc_ph   = psel & penable;
  // Zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;

  assign addr_ok = (paddr == `ROT_OFF_CTRL)    | (paddr == `ROT_OFF_INSTR)   |
                   (paddr == `ROT_OFF_BANK)    | (paddr == `ROT_OFF_WREG)    |
                   (paddr == `ROT_OFF_STATUS)  | (paddr == `ROT_OFF_IDXBASE) |
                   (paddr == `ROT_OFF_MEMADDR) | (paddr == `ROT_OFF_MEMDATA) |
                   (paddr == `ROT_OFF_LASTEA);
  assign ro_reg  = (paddr == `ROT_OFF_LASTEA);

  // Writes that would disturb an instruction in flight are refused;
  // only the status register (done clear) stays writable while busy.
  assign busy_refuse = busy & pwrite & (paddr != `ROT_OFF_STATUS);
  assign pslverr     = acc_ph & (~addr_ok | (pwrite & ro_reg) | busy_refuse);
  assign wr_acc      = acc_ph & pwrite & addr_ok & ~ro_reg & ~busy_refuse;
  assign start_req   = wr_acc & (paddr == `ROT_OFF_CTRL) & pwdata[`ROT_CTRL_START];

  assign dest_file = exec_instr_ff[`ROT_INSTR_D];
  assign core_idx  = ea_ff[MEM_AW-1:0];

  // ****************************************
  // Address resolution and rotate unit
  // ****************************************
  rot_addr_resolve u_addr
  (
    .file_addr  (exec_instr_ff[`ROT_INSTR_F_MSB:`ROT_INSTR_F_LSB]),
    .access_bit (exec_instr_ff[`ROT_INSTR_A]),
    .ext_en     (ext_en_ff),
    .bank_sel   (bank_select_reg_ff),
    .index_base (index_base_ff),
    .eff_addr   (ea_comb)
  );

  rot_rotator u_rot
  (
    .op        (exec_instr_ff[`ROT_INSTR_OP]),
    .operand   (operand_ff),
    .carry_in  (carry_ff),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  // ****************************************
  // Quarter phase sequencer
  // ****************************************
  always @*
  begin
    case (state_ff)
      ST_IDLE: nxt_state = start_req ? ST_Q1 : ST_IDLE;
      ST_Q1:   nxt_state = ST_Q2;
      ST_Q2:   nxt_state = ST_Q3;
      ST_Q3:   nxt_state = ST_Q4;
      ST_Q4:   nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // ****************************************
  // Instruction pipeline registers
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exec_instr_ff <= `ROT_INSTR_RST;
      ea_ff         <= 12'h000;
      operand_ff    <= 8'h00;
      result_ff     <= 8'h00;
      carry_new_ff  <= 1'b0;
    end
    else
    begin
      // Snapshot so software edits cannot tear an instruction
      if (start_req)
        exec_instr_ff <= instr_ff;
      if (state_ff == ST_Q1)
        ea_ff <= ea_comb;
      if (state_ff == ST_Q2)
        operand_ff <= mem[core_idx];
      if (state_ff == ST_Q3)
      begin
        result_ff    <= rot_result;
        carry_new_ff <= rot_carry;
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_ff           <= `ROT_INSTR_RST;
      ext_en_ff          <= 1'b0;
      bank_select_reg_ff <= `ROT_BANK_RST;
      wreg_ff            <= `ROT_WREG_RST;
      carry_ff           <= 1'b0;
      done_ff            <= 1'b0;
      index_base_ff      <= `ROT_IDX_RST;
      mem_addr_ff        <= {MEM_AW{1'b0}};
    end
    else
    begin
      if (wr_acc)
      begin
        case (paddr)
          `ROT_OFF_CTRL:    ext_en_ff          <= pwdata[`ROT_CTRL_EXT];
          `ROT_OFF_INSTR:   instr_ff           <= pwdata[10:0];
          `ROT_OFF_BANK:    bank_select_reg_ff <= pwdata[3:0];
          `ROT_OFF_WREG:    wreg_ff            <= pwdata[7:0];
          `ROT_OFF_STATUS:  carry_ff           <= busy ? carry_ff : pwdata[`ROT_STAT_CARRY];
          `ROT_OFF_IDXBASE: index_base_ff      <= pwdata[11:0];
          `ROT_OFF_MEMADDR: mem_addr_ff        <= pwdata[MEM_AW-1:0];
          default:          ext_en_ff          <= ext_en_ff;
        endcase
      end
      if (state_ff == ST_Q4)
      begin
        if (!dest_file)
          wreg_ff <= result_ff;
        // Left rotate leaves carry alone
        if (exec_instr_ff[`ROT_INSTR_OP] == `ROT_OP_RRC)
          carry_ff <= carry_new_ff;
      end
      // Completion sets done; a same-cycle clear loses to the set
      if (state_ff == ST_Q4)
        done_ff <= 1'b1;
      else if (wr_acc && (paddr == `ROT_OFF_STATUS) && pwdata[`ROT_STAT_DONE])
        done_ff <= 1'b0;
    end
  end

  // ****************************************
  // Data memory
  // ****************************************
  // No reset: contents are data, loaded by software before use
  always @(posedge pclk)
  begin
    if ((state_ff == ST_Q4) && dest_file)
      mem[core_idx] <= result_ff;
    else if (wr_acc && (paddr == `ROT_OFF_MEMDATA))
      mem[mem_addr_ff] <= pwdata[7:0];
  end

  // ****************************************
  // Read path
  // ****************************************
  always @*
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      `ROT_OFF_CTRL:    rd_mux[`ROT_CTRL_EXT] = ext_en_ff;
      `ROT_OFF_INSTR:   rd_mux[10:0] = instr_ff;
      `ROT_OFF_BANK:    rd_mux[3:0] = bank_select_reg_ff;
      `ROT_OFF_WREG:    rd_mux[7:0] = wreg_ff;
      `ROT_OFF_STATUS:  rd_mux[2:0] = {done_ff, busy, carry_ff};
      `ROT_OFF_IDXBASE: rd_mux[11:0] = index_base_ff;
      `ROT_OFF_MEMADDR: rd_mux[MEM_AW-1:0] = mem_addr_ff;
      `ROT_OFF_MEMDATA: rd_mux[7:0] = mem[mem_addr_ff];
      `ROT_OFF_LASTEA:  rd_mux[11:0] = ea_ff;
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Read data captured in setup so the access phase sees a flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup_ph)
      prdata <= pwrite ? 32'h00000000 : rd_mux;
  end
endmodule

// [rot_datapath_assertions.sv]
// Port-level checker for the rotate datapath
`timescale 1ns/1ps
module rot_chk
#(
  parameter MEM_AW = 12
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic [2:0]  cnt_ff;
  logic [10:0] ins_ff;
  logic [3:0]  bnk_ff;
  logic        ext_ff;
  logic [11:0] idx_ff;
  logic [11:0] ea_ff;
  logic [1:0]  md_ff;
  logic [7:0]  w_ff;
  logic        wk_ff;
  wire         rd = psel & penable & !pwrite;
  wire         wr = psel & penable & pwrite & !pslverr;
  wire         go = wr && paddr == 12'h000 && pwdata[0] && cnt_ff == 3'h0;
  wire  [7:0]  f  = ins_ff[7:0];
  wire  [1:0]  md = ins_ff[9] ? 2'h1 : (ext_ff && f <= 8'h5F) ? 2'h2 : 2'h0;
  wire  [11:0] ea = md == 2'h1 ? {bnk_ff, f} : md == 2'h2 ? idx_ff + {4'h0, f} :
                    {f < 8'h60 ? 4'h0 : 4'hF, f};
  // Read data lags register state by one edge, hence the past values below
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 3'h0;
      ins_ff <= 11'h300;
      bnk_ff <= 4'h0;
      ext_ff <= 1'b0;
      idx_ff <= 12'h000;
      ea_ff  <= 12'h000;
      md_ff  <= 2'h3;
      w_ff   <= 8'h00;
      wk_ff  <= 1'b1;
    end
    else
    begin
      cnt_ff <= go ? 3'h4 : cnt_ff - {2'h0, cnt_ff != 3'h0};
      wk_ff  <= (wr && paddr == 12'h00C) | (wk_ff & !(cnt_ff == 3'h4 && !ins_ff[8]));
      if (wr)
      begin
        case (paddr)
          12'h000: ext_ff <= pwdata[1];
          12'h004: ins_ff <= pwdata[10:0];
          12'h008: bnk_ff <= pwdata[3:0];
          12'h00C: w_ff <= pwdata[7:0];
          12'h014: idx_ff <= pwdata[11:0];
          default: ;
        endcase
      end
      if (cnt_ff == 3'h4)
      begin
        ea_ff <= ea & ((12'h001 << MEM_AW) - 12'h001);
        md_ff <= md;
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_busy;
    go |-> ##2 (!(rd && paddr == 12'h010) || prdata[1]) [*4];
  endproperty
  a_busy: assert property (p_busy) else $error("busy low in run");
  property p_idle;
    rd && paddr == 12'h010 && $past(cnt_ff) == 3'h0 |-> !prdata[1];
  endproperty
  a_idle: assert property (p_idle) else $error("busy high when idle");
  property p_refuse;
    psel && penable && pwrite && paddr != 12'h010 && cnt_ff != 3'h0 |-> pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("write taken in run");
  property p_dest;
    rd && paddr == 12'h00C && $past(wk_ff) |-> prdata[7:0] == $past(w_ff);
  endproperty
  a_dest: assert property (p_dest) else $error("work reg disturbed");
  property p_acc;
    rd && paddr == 12'h020 && $past(md_ff) == 2'h0 |-> prdata[11:0] == $past(ea_ff);
  endproperty
  a_acc: assert property (p_acc) else $error("access bank address");
  property p_bank;
    rd && paddr == 12'h020 && $past(md_ff) == 2'h1 |-> prdata[11:0] == $past(ea_ff);
  endproperty
  a_bank: assert property (p_bank) else $error("banked address");
  property p_idx;
    rd && paddr == 12'h020 && $past(md_ff) == 2'h2 |-> prdata[11:0] == $past(ea_ff);
  endproperty
  a_idx: assert property (p_idx) else $error("indexed address");
endmodule

bind rot_datapath rot_chk #(.MEM_AW(MEM_AW)) rot_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [tb.sv]
// Self-checking bench for the rotate datapath
`timescale 1ns/1ps
module tb;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  logic [31:0] rdat;
  logic        serr;
  logic        rdy;
  logic [63:0] r;
  logic [7:0]  f, x, w0, res;
  logic [3:0]  bk;
  logic [11:0] ix, e;
  logic        op, d, a, ex, c, nc;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  int          seed = 32'h734F8713;
  always #2 pclk = ~pclk;
  rot_datapath #(.MEM_AW(12)) rot_datapath_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, runs are under a thousand cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held up to the edge that samples pready; next setup or caller releases it
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] dt);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    rdy = pready;
    while (rdy !== 1'b1)
    begin
      @(posedge pclk);
      rdy = pready;
    end
    rdat = prdata;
    serr = pslverr;
  endtask
  function automatic logic [11:0] ea_of(logic a, logic ex, logic [7:0] f, logic [3:0] b,
                                        logic [11:0] ix);
    if (a)
      return {b, f};
    if (ex && f <= 8'h5F)
      return ix + {4'h0, f};
    return {f < 8'h60 ? 4'h0 : 4'hF, f};
  endfunction
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat, 32'h300);
    apb(1'b0, 12'h024, 32'h0);
    chk({31'h0, serr}, 32'h1);
    for (int i = 0; i < 30; i++)
    begin
      r = {$random(seed), $random(seed)};
      {ix, w0, x, bk, f, c, ex, a, d, op} = r[44:0];
      // Corners: indexed limit, access bank split, low access bank
      if (i < 3)
      begin
        a = 1'b0;
        ex = i != 2;
        f = i == 1 ? 8'h60 : 8'h5F;
        ix = i == 0 ? 12'hFF0 : ix;
      end
      e = ea_of(a, ex, f, bk, ix);
      res = op ? {c, x[7:1]} : {x[6:0], x[7]};
      nc = op ? x[0] : c;
      apb(1'b1, 12'h018, {20'h0, e});
      apb(1'b1, 12'h01C, {24'h0, x});
      apb(1'b1, 12'h00C, {24'h0, w0});
      apb(1'b1, 12'h010, {29'h0, 2'h2, c});
      apb(1'b1, 12'h008, {28'h0, bk});
      apb(1'b1, 12'h014, {20'h0, ix});
      apb(1'b1, 12'h004, {21'h0, op, a, d, f});
      apb(1'b1, 12'h000, {30'h0, ex, 1'b1});
      chk({31'h0, serr}, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, rdat[1]}, 32'h1);
      apb(1'b1, 12'h008, 32'h0);
      chk({31'h0, serr}, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk(rdat, {29'h0, 3'h4 | {2'h0, nc}});
      apb(1'b0, 12'h020, 32'h0);
      chk(rdat, {20'h0, e});
      apb(1'b0, 12'h00C, 32'h0);
      chk(rdat, {24'h0, d ? w0 : res});
      apb(1'b0, 12'h01C, 32'h0);
      chk(rdat, {24'h0, d ? res : x});
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    finish_test;
  end
endmodule
